// ---- sim/dis_host_model.sv ----
// host controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module dis_host_model
	import dis_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic serial_out_i,
	output var dis_link_in_s link_o
);
	initial link_o = '0;
	// clock stands low between frames, enable only while shifting
	task automatic frame(input logic ld, en, input logic [7:0] din,
		output logic [7:0] dout);
		if (ld) begin
			@(posedge ref_clk_i) link_o.load <= 1'b1;
			@(posedge ref_clk_i) link_o.load <= 1'b0;
			repeat (2) @(posedge ref_clk_i);
		end
		for (int i = 7; i >= 0; i--) begin
			@(posedge ref_clk_i);
			dout[i] = serial_out_i;
			link_o.data_in <= din[i];
			link_o.enable <= en;
			link_o.clk <= 1'b1;
			repeat (3) @(posedge ref_clk_i);
			link_o.clk <= 1'b0;
			repeat (3) @(posedge ref_clk_i);
		end
		link_o.enable <= 1'b0;
		link_o.data_in <= ~link_o.data_in;
	endtask
endmodule
`default_nettype wire

// ---- sim/dis_top_props.sv ----
// port assertions of the serializer
`timescale 1ns/1ps
`default_nettype none
module dis_top_props
	import dis_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic overtemp_sensor_i,
	input wire dis_link_in_s link_i,
	input wire dis_bus_req_s bus_i,
	input wire logic [31:0] rdata_o,
	input wire logic serial_out_o,
	input wire logic overtemp_n_o,
	input wire logic [7:0] led_return_drive_o,
	input wire logic irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence quiet_s;
		!link_i.load && !(link_i.enable && link_i.clk && !$past(link_i.clk));
	endsequence
	sequence mask_wr_s;
		bus_i.wr && bus_i.addr == 4'h4;
	endsequence
	sequence mask_rd_s;
		bus_i.rd && bus_i.addr == 4'h4;
	endsequence
	ot_follow_a: assert property (!$past(sys_rst_i) |->
		overtemp_n_o == !$past(overtemp_sensor_i)) else $error("overtemp lag");
	ser_hold_a: assert property (quiet_s ##1 quiet_s |=>
		$stable(serial_out_o)) else $error("serial out moved");
	rd_idle_a: assert property (!bus_i.rd |=> rdata_o == 32'h0)
		else $error("data without read");
	rd_unmap_a: assert property (bus_i.rd && bus_i.addr[1:0] != 2'h0 |=>
		rdata_o == 32'h0) else $error("unmapped read");
	mask_back_a: assert property (mask_wr_s ##1 mask_rd_s |=>
		rdata_o == {29'h0, $past(bus_i.wdata[2:0], 2)}) else $error("mask");
	irq_off_a: assert property (bus_i.wr && bus_i.addr == 4'h4 &&
		bus_i.wdata[2:0] == 3'h0 |-> ##2 !irq_o) else $error("irq masked");
	irq_ot_a: assert property (bus_i.wr && bus_i.addr == 4'h4 &&
		bus_i.wdata[0] ##1 overtemp_sensor_i [*2] |=> irq_o)
		else $error("irq missing");
	led_off_a: assert property (bus_i.wr && bus_i.addr == 4'hc &&
		!bus_i.wdata[0] |-> ##2 led_return_drive_o == 8'h0) else $error("led");
	ld_stat_a: assert property (link_i.load ##1 bus_i.rd &&
		bus_i.addr == 4'h0 |=> rdata_o[1]) else $error("load event lost");
endmodule
bind dis_top dis_top_props u_props (.ref_clk_i, .sys_rst_i,
	.overtemp_sensor_i, .link_i, .bus_i, .rdata_o, .serial_out_o,
	.overtemp_n_o, .led_return_drive_o, .irq_o);
`default_nettype wire

// ---- sim/dis_top_tb.sv ----
// testbench of the debounced input serializer
`timescale 1ns/1ps
`default_nettype none
module dis_top_tb
	import dis_pkg::*;
;
	logic ref_clk_i, sys_rst_i, sel_lo, sel_hi, ot, sout, par, ot_n, irq;
	logic [7:0] fin, led, dout;
	logic [7:0] pat [3] = '{8'h3c, 8'ha7, 8'hc3};
	logic [31:0] rdata;
	dis_link_in_s link;
	dis_bus_req_s bus;
	int n_mismatch = 0;
	int n_checks = 0;
	int ms;
	dis_top #(.MS_CYCLES(4)) u_dut (.ref_clk_i, .sys_rst_i,
		.debounce_sel_lo_i(sel_lo), .debounce_sel_hi_i(sel_hi),
		.field_input_i(fin), .overtemp_sensor_i(ot), .link_i(link),
		.bus_i(bus), .rdata_o(rdata), .serial_out_o(sout), .parity_o(par),
		.overtemp_n_o(ot_n), .led_return_drive_o(led), .irq_o(irq));
	dis_host_model u_host (.ref_clk_i, .serial_out_i(sout), .link_o(link));
	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic [3:0] a, input logic [31:0] d,
		input logic w, r);
		@(posedge ref_clk_i);
		bus <= {a, d, w, r};
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		acc(a, d, 1'b1, 1'b0);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, msk);
		acc(a, 32'h0, 1'b0, 1'b1);
		acc(4'h0, 32'h0, 1'b0, 1'b0);
		#1 chk(rdata & msk, exp);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		sys_rst_i = 1'b1;
		{sel_lo, sel_hi, ot, fin, bus} = {1'b1, 48'h0};
		repeat (10) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		#1 chk({sout, par, ot_n, irq, led}, 32'h600);
		rd(4'hc, 32'h1, '1);
		rd(4'h8, 32'h100, '1);
		rd(4'h2, 32'h0, '1);
		for (int k = 0; k < 3; k++) begin
			ms = (k == 2) ? 3 : k;
			@(posedge ref_clk_i);
			sel_lo <= (k != 1);
			sel_hi <= (k != 0);
			repeat (20) @(posedge ref_clk_i);
			fin <= pat[k];
			if (k != 0) rd(4'h8, pat[k-1], 32'hff);
			repeat (ms * 4 + 6) @(posedge ref_clk_i);
			rd(4'h8, pat[k], 32'hff);
			chk(led, pat[k]);
			$display("debounce mode %0d done", k);
		end
		for (int j = 0; j < 2; j++) begin
			@(posedge ref_clk_i);
			fin <= pat[j];
			repeat (20) @(posedge ref_clk_i);
			fork
				u_host.frame(1'b1, 1'b1, 8'h96, dout);
				begin
					@(posedge ref_clk_i);
					rd(4'h0, 32'h2, 32'h2);
				end
			join
			chk(dout, pat[j]);
			chk(^{par, dout}, 1'b1);
		end
		u_host.frame(1'b0, 1'b1, 8'h00, dout);
		chk(dout, 8'h96);
		u_host.frame(1'b0, 1'b0, 8'hff, dout);
		chk(dout, 8'h00);
		$display("serial tests done");
		wr(4'h4, 32'h1);
		acc(4'h0, 32'h0, 1'b0, 1'b0);
		ot <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1 chk(irq, 1'b1);
		chk(ot_n, 1'b0);
		@(posedge ref_clk_i);
		ot <= 1'b0;
		rd(4'h0, 32'h1, 32'h1);
		rd(4'h0, 32'h0, 32'h1);
		repeat (3) @(posedge ref_clk_i);
		#1 chk(irq, 1'b0);
		wr(4'h4, 32'h0);
		rd(4'h4, 32'h0, '1);
		wr(4'hc, 32'h0);
		rd(4'hc, 32'h0, '1);
		chk(led, 8'h0);
		$display("register tests done");
		report_and_stop();
	end
endmodule
`default_nettype wire

// ---- verilog/dis_debounce.sv ----
// per-channel debounce filter counting millisecond ticks
`timescale 1ns/1ps
`default_nettype none
`include "dis_defs.svh"
module dis_debounce #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic ms_tick_i,
	input wire logic [1:0] db_ms_i,
	input wire logic [WIDTH-1:0] raw_i,
	output logic [WIDTH-1:0] stable_o
);
	logic [1:0] cnt_reg [WIDTH];

	// ticks are free running: the first tick after a change only starts
	// the count, so a level must hold db_ms_i to db_ms_i+1 ms to be taken
	always_ff @(posedge ref_clk_i) begin
		for (int i = 0; i < WIDTH; i++) begin
			if (sys_rst_i) begin
				stable_o[i] <= 1'b0;
				cnt_reg[i] <= 2'h0;
			end else if (raw_i[i] == stable_o[i]) begin
				cnt_reg[i] <= 2'h0;
			end else if (db_ms_i == `DIS_DB_NONE_MS) begin
				stable_o[i] <= raw_i[i];
				cnt_reg[i] <= 2'h0;
			end else if (ms_tick_i) begin
				if (cnt_reg[i] >= db_ms_i) begin
					stable_o[i] <= raw_i[i];
					cnt_reg[i] <= 2'h0;
				end else begin
					cnt_reg[i] <= cnt_reg[i] + 2'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- verilog/dis_defs.svh ----
// constants of the debounced input serializer: offsets, fields, timing
`ifndef DIS_DEFS_SVH
`define DIS_DEFS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define DIS_ADDR_W 4
`define DIS_OFS_STATUS 4'h0
`define DIS_OFS_MASK 4'h4
`define DIS_OFS_INPUTS 4'h8
`define DIS_OFS_CTRL 4'hc

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DIS_EV_OVERTEMP 0
`define DIS_EV_LOAD 1
`define DIS_EV_CHANGE 2
`define DIS_EV_W 3
`define DIS_CTRL_LED_EN 0
`define DIS_INPUTS_PARITY 8

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DIS_RST_MASK 3'h0
`define DIS_RST_CTRL 1'h1
`define DIS_RST_SHIFT 8'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define DIS_CLK_PERIOD_NS 50
`define DIS_MS_NS 1000000
`define DIS_MS_CYCLES (`DIS_MS_NS / `DIS_CLK_PERIOD_NS)
`define DIS_DB_NONE_MS 2'h0
`define DIS_DB_SHORT_MS 2'h1
`define DIS_DB_LONG_MS 2'h3

`endif

// ---- verilog/dis_pkg.sv ----
// types shared by the debounced input serializer
`default_nettype none
package dis_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dis_bus_req_s;

	typedef struct packed {
		logic clk;
		logic enable;
		logic load;
		logic data_in;
	} dis_link_in_s;

	typedef enum logic [1:0] {
		DIS_DB_OFF,
		DIS_DB_SHORT,
		DIS_DB_LONG
	} dis_db_mode_e;
endpackage
`default_nettype wire

// ---- verilog/dis_top.sv ----
// eight-channel debounced input serializer with diagnostics
//
// Contract
// - debounce each input, zero to three ms
// - select pins encode 0, 1 or 3 ms
// - load pulse captures all inputs at once
// - serial input shifts in behind outgoing bits
// - odd parity over the captured data
// - overtemp output low while sensor reports hot
// - led drive on while channel is active
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dis_defs.svh"
module dis_top
	import dis_pkg::*;
#(
	parameter int CHANNELS = 8,
	parameter int MS_CYCLES = `DIS_MS_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic debounce_sel_lo_i,
	input wire logic debounce_sel_hi_i,
	input wire logic [CHANNELS-1:0] field_input_i,
	input wire logic overtemp_sensor_i,
	input wire dis_link_in_s link_i,
	input wire dis_bus_req_s bus_i,
	output logic [31:0] rdata_o,
	output logic serial_out_o,
	output logic parity_o,
	output logic overtemp_n_o,
	output logic [CHANNELS-1:0] led_return_drive_o,
	output logic irq_o
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic odd_parity(input logic [CHANNELS-1:0] d);
		return ~(^d);
	endfunction

	function automatic logic [1:0] decode_db(input logic lo, input logic hi);
		dis_db_mode_e m;
		m = DIS_DB_LONG;
		if (lo && !hi)
			m = DIS_DB_OFF;
		else if (!lo && hi)
			m = DIS_DB_SHORT;
		case (m)
			DIS_DB_OFF: return `DIS_DB_NONE_MS;
			DIS_DB_SHORT: return `DIS_DB_SHORT_MS;
			DIS_DB_LONG: return `DIS_DB_LONG_MS;
			default: return `DIS_DB_LONG_MS;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// millisecond tick
	// ---------------------------------------------------------------
	localparam int MSW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
	logic [MSW-1:0] ms_cnt_reg;
	logic ms_tick_reg;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ms_cnt_reg <= '0;
			ms_tick_reg <= 1'b0;
		end else if (ms_cnt_reg == MSW'(MS_CYCLES - 1)) begin
			ms_cnt_reg <= '0;
			ms_tick_reg <= 1'b1;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 1'b1;
			ms_tick_reg <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// debounce
	// ---------------------------------------------------------------
	logic [1:0] db_ms_reg;
	logic [CHANNELS-1:0] stable;

	// select pins are static straps; re-decoded each cycle
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			db_ms_reg <= `DIS_DB_LONG_MS;
		else
			db_ms_reg <= decode_db(debounce_sel_lo_i, debounce_sel_hi_i);
	end

	dis_debounce #(
		.WIDTH(CHANNELS)
	) u_debounce (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.ms_tick_i(ms_tick_reg),
		.db_ms_i(db_ms_reg),
		.raw_i(field_input_i),
		.stable_o(stable)
	);

	// ---------------------------------------------------------------
	// serial link
	// ---------------------------------------------------------------
	logic sclk_reg;
	logic sclk_rise;
	logic [CHANNELS-1:0] shift_reg;
	logic load_ev;

	assign sclk_rise = link_i.clk & ~sclk_reg;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			sclk_reg <= 1'b0;
		else
			sclk_reg <= link_i.clk;
	end

	// load is a level: while held the register follows the inputs,
	// so its falling edge fixes the snapshot
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			shift_reg <= CHANNELS'(`DIS_RST_SHIFT);
			parity_o <= 1'b1;
		end else if (link_i.load) begin
			shift_reg <= stable;
			parity_o <= odd_parity(stable);
		end else if (sclk_rise && link_i.enable) begin
			shift_reg <= {shift_reg[CHANNELS-2:0], link_i.data_in};
		end
	end

	assign load_ev = link_i.load;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			serial_out_o <= 1'b0;
		else
			serial_out_o <= shift_reg[CHANNELS-1];
	end

	// ---------------------------------------------------------------
	// diagnostics and leds
	// ---------------------------------------------------------------
	logic ctrl_led_en_reg;
	logic [CHANNELS-1:0] stable_prev_reg;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			overtemp_n_o <= 1'b1;
		else
			overtemp_n_o <= ~overtemp_sensor_i;
	end

	// software may blank the leds, e.g. for a lamp test or to save power
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			led_return_drive_o <= '0;
		else if (ctrl_led_en_reg)
			led_return_drive_o <= stable;
		else
			led_return_drive_o <= '0;
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			stable_prev_reg <= '0;
		else
			stable_prev_reg <= stable;
	end

	// ---------------------------------------------------------------
	// status, mask and interrupt
	// ---------------------------------------------------------------
	logic [`DIS_EV_W-1:0] status_reg;
	logic [`DIS_EV_W-1:0] mask_reg;
	logic [`DIS_EV_W-1:0] events;
	logic status_rd;

	assign events[`DIS_EV_OVERTEMP] = overtemp_sensor_i;
	assign events[`DIS_EV_LOAD] = load_ev;
	assign events[`DIS_EV_CHANGE] = |(stable ^ stable_prev_reg);
	assign status_rd = bus_i.rd && (bus_i.addr == `DIS_OFS_STATUS);

	// an event in the clearing read cycle survives: set wins
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			status_reg <= '0;
		else if (status_rd)
			status_reg <= events;
		else
			status_reg <= status_reg | events;
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(status_reg & mask_reg);
	end

	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			mask_reg <= `DIS_RST_MASK;
			ctrl_led_en_reg <= `DIS_RST_CTRL;
		end else if (bus_i.wr) begin
			case (bus_i.addr)
				`DIS_OFS_MASK: mask_reg <= bus_i.wdata[`DIS_EV_W-1:0];
				`DIS_OFS_CTRL: ctrl_led_en_reg <= bus_i.wdata[`DIS_CTRL_LED_EN];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rdata_o <= '0;
		end else if (bus_i.rd) begin
			case (bus_i.addr)
				`DIS_OFS_STATUS: rdata_o <= 32'(status_reg);
				`DIS_OFS_MASK: rdata_o <= 32'(mask_reg);
				`DIS_OFS_INPUTS: rdata_o <= 32'({parity_o, stable});
				`DIS_OFS_CTRL: rdata_o <= 32'(ctrl_led_en_reg);
				default: rdata_o <= '0;
			endcase
		end else begin
			rdata_o <= '0;
		end
	end
endmodule
`default_nettype wire
